// ---- core/pib_pkg.sv ----
// Purpose: shared constants for the inbound processor-bus master
// Assumes: 64-bit processor data bus, 32-byte cache lines
// Notes:   fifo occupancy is counted in 64-bit entries

package pib_pkg;

	// ****************************************
	// pci commands
	// ****************************************
	localparam logic [3:0] CMD_MEM_READ      = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE     = 4'h7;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;

	// ****************************************
	// transfer type codes
	// ****************************************
	localparam logic [4:0] TT_READ        = 5'h0a;
	localparam logic [4:0] TT_READ_MODIFY = 5'h0e;
	localparam logic [4:0] TT_WRITE_KILL  = 5'h06;
	localparam logic [4:0] TT_WRITE_FLUSH = 5'h02;

	// ****************************************
	// geometry and reset values
	// ****************************************
	localparam int         OCC_W          = 6;
	localparam logic [5:0] BEATS_PER_LINE = 6'h04;
	localparam logic [4:0] FETCH_PREFETCH = 5'h10;
	localparam logic [4:0] FETCH_SINGLE   = 5'h04;
	localparam logic [3:0] LINES_PREFETCH = 4'h4;
	localparam logic [4:0] LINE_LAST_BYTE = 5'h1f;
	localparam logic [31:0] LINE_BYTES    = 32'h0000_0020;
	localparam logic [31:0] BEAT_BYTES    = 32'h0000_0008;
	localparam logic       HOG_RESET      = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ  = 2'b01,
		ST_ADDR = 2'b10,
		ST_DATA = 2'b11
	} pib_state_type;

endpackage

// ---- core/pib_line_cmp.sv ----
// Purpose: threshold compare of fifo occupancy in cache lines
// Assumes: code 00..11 as in the threshold fields
// Notes:   ge_o is the write start test, le_o the read refill test

`timescale 1ns/100ps
`default_nettype none

module pib_line_cmp (
	input  wire logic [1:0] code_i,
	input  wire logic [3:0] lines_i,
	output logic            ge_o,
	output logic            le_o
);
	import pib_pkg::*;

	wire logic [3:0] start_lines = LINES_PREFETCH - {2'b00, code_i};

	assign ge_o = (lines_i >= start_lines);
	assign le_o = (lines_i <= {2'b00, code_i});

endmodule

`default_nettype wire

// ---- core/pib_cpu_master.sv ----
// Purpose: processor-bus master for inbound pci memory transactions
// Assumes: pci slave and fifo storage run on CLK_I and sit outside
// Notes:   addresses are beat aligned; every single beat moves 8 bytes
//
// Function
// - write drain runs while the pci slave keeps filling the fifo
// - posting off: start and continue writes with one entry present
// - posting on: start at 4/3/2/1 lines by code, continue at one line
// - read-ahead prefetches bursts into fifo to serve the pci read
// - no read-ahead: fetch one line, another only after data taken in frame
// - read-ahead: fetch 4 lines, refill 4 when lines fall to code or below
// - read threshold only with read-ahead; multiple threshold always for read multiple
// - on read completion discard leftover fifo data
// - prefetched fifo data is never snooped against processor traffic
// - never read past the translated end of the mapped window
// - global attribute alone drives global snoop for whole transfer
// - reads use 01010, or 01110 with intent-to-modify set
// - writes use 00110 for bursts, 00010 for singles
// - bus hog keeps request asserted for whole transaction
// - without hog request follows fifo fill and drain needs
// - hog enable resets to disabled
// - singles up to line boundary, for read and write tails and at window end, else bursts
// - read-ahead start at 0x08..0x17 bursts whole line, drops low beats

`timescale 1ns/100ps
`default_nettype none

module pib_cpu_master (
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        WRITE_POST_ENABLE_I,
	input  wire logic [1:0]  WRITE_FIFO_THRESHOLD_I,
	input  wire logic        READ_AHEAD_ENABLE_I,
	input  wire logic [1:0]  READ_FIFO_THRESHOLD_I,
	input  wire logic [1:0]  READ_MULTIPLE_FIFO_THRESHOLD_I,
	input  wire logic        INTENT_MODIFY_SELECT_I,
	input  wire logic        GLOBAL_ATTR_SELECT_I,
	input  wire logic        MASTER_BUS_HOG_ENABLE_I,
	input  wire logic        XACT_START_I,
	input  wire logic [3:0]  XACT_CMD_I,
	input  wire logic [31:0] XACT_ADDR_I,
	input  wire logic [31:0] XACT_LIMIT_I,
	input  wire logic        XACT_DONE_I,
	input  wire logic        PCI_FRAME_ACTIVE_I,
	input  wire logic        FIFO_PUSH_I,
	input  wire logic        FIFO_POP_I,
	input  wire logic [63:0] FIFO_DATA_I,
	output logic             FIFO_POP_O,
	output logic             FIFO_PUSH_O,
	output logic [63:0]      FIFO_DATA_O,
	output logic             FIFO_FLUSH_O,
	output logic [3:0]       FIFO_LINES_O,
	output logic             BUSY_O,
	output logic             BR_N_O,
	input  wire logic        BG_N_I,
	output logic             TS_N_O,
	output logic [31:0]      ADDR_O,
	output logic [4:0]       TT_O,
	output logic             TBST_N_O,
	output logic             GBL_N_O,
	input  wire logic        AACK_N_I,
	input  wire logic        TA_N_I,
	output logic [63:0]      DATA_O,
	input  wire logic [63:0] DATA_I
);
	import pib_pkg::*;

	// ****************************************
	// state
	// ****************************************
	pib_state_type      st_q, st_d;
	logic               act_q, rd_q, pf_q, inv_q, gbl_q, hog_q, done_q, cont_q, more_q;
	logic [1:0]         thr_q, beat_q, skip_q;
	logic               burst_q, flush_q, ts_q, push_q;
	logic [31:0]        cur_q, lim_q, addr_q;
	logic [4:0]         rem_q, tt_q;
	logic [OCC_W-1:0]   occ_q;
	logic [63:0]        fdata_q, wdata_q;

	// ****************************************
	// occupancy
	// ****************************************
	wire logic [3:0] lines   = occ_q[OCC_W-1:2];
	wire logic       ta      = (st_q == ST_DATA) && !TA_N_I;
	wire logic       drain   = ta && !rd_q;
	wire logic       fill    = ta && rd_q && (beat_q >= skip_q);
	// pci slave pushes count even while a drain burst is running
	wire logic       inc     = (FIFO_PUSH_I && act_q && !rd_q) || fill;
	wire logic       dec     = drain || (FIFO_POP_I && rd_q);
	wire logic       last    = ta && (!burst_q || (beat_q == 2'h3));

	// ****************************************
	// threshold compares
	// ****************************************
	logic wr_ge, rd_le;

	pib_line_cmp u_wr_cmp (
		.code_i  (WRITE_FIFO_THRESHOLD_I),
		.lines_i (lines),
		.ge_o    (wr_ge),
		.le_o    ()
	);

	pib_line_cmp u_rd_cmp (
		.code_i  (thr_q),
		.lines_i (lines),
		.ge_o    (),
		.le_o    (rd_le)
	);

	// ****************************************
	// transaction decode at start
	// ****************************************
	wire logic st_is_rd  = (XACT_CMD_I == CMD_MEM_READ) || (XACT_CMD_I == CMD_MEM_READ_MULT)
	                       || (XACT_CMD_I == CMD_MEM_READ_LINE);
	wire logic st_is_rm  = (XACT_CMD_I == CMD_MEM_READ_MULT);
	wire logic st_pf     = st_is_rm || READ_AHEAD_ENABLE_I;
	wire logic [1:0] st_thr = st_is_rm ? READ_MULTIPLE_FIFO_THRESHOLD_I
	                                   : READ_FIFO_THRESHOLD_I;
	wire logic start     = XACT_START_I && !act_q;

	// ****************************************
	// write decision
	// ****************************************
	wire logic       aligned  = (cur_q[4:3] == 2'b00);
	wire logic       occ_any  = (occ_q != '0);
	wire logic       occ_line = (occ_q >= BEATS_PER_LINE);
	wire logic       wr_post  = cont_q ? occ_line : wr_ge;
	wire logic       wr_go    = WRITE_POST_ENABLE_I ? (wr_post || (done_q && occ_any))
	                                                : occ_any;
	// bursts only from a line boundary with a full line queued
	wire logic       wr_burst = aligned && occ_line;

	// ****************************************
	// read decision
	// ****************************************
	wire logic [31:0] line_base = {cur_q[31:5], 5'h00};
	wire logic [31:0] line_end  = {cur_q[31:5], LINE_LAST_BYTE};
	wire logic        beyond    = (cur_q > lim_q);
	wire logic        burst_ok  = (line_end <= lim_q);
	wire logic        mid_line  = (cur_q[4:3] == 2'b01) || (cur_q[4:3] == 2'b10);
	wire logic        rd_full   = aligned && burst_ok && (rem_q >= FETCH_SINGLE);
	wire logic        rd_skip   = pf_q && mid_line && burst_ok;
	wire logic        rd_burst  = rd_full || rd_skip;
	wire logic        rd_go     = (rem_q != '0) && !beyond && !done_q;
	wire logic [4:0]  rd_take   = rd_burst ? (FETCH_SINGLE - {3'b000, rd_skip ? cur_q[4:3] : 2'b00})
	                                       : 5'h01;
	wire logic        go        = act_q && (rd_q ? rd_go : wr_go);
	wire logic        burst_sel = rd_q ? rd_burst : wr_burst;
	wire logic [31:0] xaddr     = (rd_q && rd_skip) ? line_base : cur_q;
	wire logic [31:0] next_cur  = burst_sel ? (xaddr + LINE_BYTES) : (cur_q + BEAT_BYTES);
	wire logic [4:0]  tt_sel    = rd_q ? (inv_q ? TT_READ_MODIFY : TT_READ)
	                                   : (burst_sel ? TT_WRITE_KILL : TT_WRITE_FLUSH);
	// refill only between transfers, so beats still in flight are counted first
	wire logic        rd_refill = rd_q && (rem_q == '0) && !done_q && (st_q == ST_IDLE) &&
	                              (pf_q ? rd_le : more_q);
	wire logic        finish    = (st_q == ST_IDLE) && act_q && done_q &&
	                              (rd_q || !occ_any);

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: if (go && !finish && !rd_refill) st_d = ST_REQ;
			ST_REQ:  if (!BG_N_I) st_d = ST_ADDR;
			ST_ADDR: if (!AACK_N_I) st_d = ST_DATA;
			ST_DATA: if (last) st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st_q   <= ST_IDLE;
			ts_q   <= 1'b0;
			beat_q <= 2'h0;
		end else begin
			st_q   <= st_d;
			ts_q   <= (st_q == ST_REQ) && !BG_N_I;
			beat_q <= (st_q != ST_DATA) ? 2'h0 : (beat_q + {1'b0, ta});
		end
	end

	// ****************************************
	// transaction context
	// ****************************************
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			act_q  <= 1'b0;
			rd_q   <= 1'b0;
			pf_q   <= 1'b0;
			inv_q  <= 1'b0;
			gbl_q  <= 1'b0;
			thr_q  <= 2'h0;
			done_q <= 1'b0;
			cont_q <= 1'b0;
			more_q <= 1'b0;
			rem_q  <= 5'h00;
			cur_q  <= 32'h0000_0000;
			lim_q  <= 32'h0000_0000;
		end else if (start) begin
			act_q  <= 1'b1;
			rd_q   <= st_is_rd;
			pf_q   <= st_pf;
			inv_q  <= INTENT_MODIFY_SELECT_I;
			gbl_q  <= GLOBAL_ATTR_SELECT_I;
			thr_q  <= st_thr;
			done_q <= 1'b0;
			cont_q <= 1'b0;
			more_q <= 1'b0;
			rem_q  <= st_pf ? FETCH_PREFETCH : FETCH_SINGLE;
			cur_q  <= XACT_ADDR_I;
			lim_q  <= XACT_LIMIT_I;
		end else begin
			if (XACT_DONE_I) done_q <= 1'b1;
			if (finish) act_q <= 1'b0;
			if (rd_refill) begin
				rem_q  <= pf_q ? FETCH_PREFETCH : FETCH_SINGLE;
				more_q <= 1'b0;
			end else if ((st_q == ST_IDLE) && (st_d == ST_REQ)) begin
				rem_q  <= (rem_q > rd_take) ? (rem_q - rd_take) : 5'h00;
				cur_q  <= next_cur;
			end
			// set wins: a pop in the refill cycle still asks for another line
			if (FIFO_POP_I && PCI_FRAME_ACTIVE_I) more_q <= 1'b1;
			if (last && !rd_q) cont_q <= 1'b1;
		end
	end

	// ****************************************
	// bus outputs and fifo side
	// ****************************************
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			burst_q <= 1'b0;
			skip_q  <= 2'h0;
			addr_q  <= 32'h0000_0000;
			tt_q    <= 5'h00;
			hog_q   <= HOG_RESET;
			flush_q <= 1'b0;
			push_q  <= 1'b0;
			occ_q   <= '0;
			fdata_q <= 64'h0;
			wdata_q <= 64'h0;
		end else begin
			hog_q   <= MASTER_BUS_HOG_ENABLE_I;
			flush_q <= finish && rd_q;
			push_q  <= fill;
			if (fill) fdata_q <= DATA_I;
			wdata_q <= FIFO_DATA_I;
			if ((st_q == ST_IDLE) && (st_d == ST_REQ)) begin
				burst_q <= burst_sel;
				skip_q  <= (rd_q && rd_skip) ? cur_q[4:3] : 2'h0;
				addr_q  <= xaddr;
				tt_q    <= tt_sel;
			end
			// leftover prefetched entries are dropped, never snooped
			if (finish && rd_q) occ_q <= '0;
			else occ_q <= occ_q + OCC_W'(inc) - OCC_W'(dec);
		end
	end

	// hog holds request for the whole transaction, else only when needed
	wire logic req = hog_q ? act_q : (st_q == ST_REQ);

	assign BR_N_O       = !req;
	assign TS_N_O       = !ts_q;
	assign ADDR_O       = addr_q;
	assign TT_O         = tt_q;
	assign TBST_N_O     = !burst_q;
	assign GBL_N_O      = !(gbl_q && (st_q != ST_IDLE));
	assign DATA_O       = wdata_q;
	assign FIFO_POP_O   = drain;
	assign FIFO_PUSH_O  = push_q;
	assign FIFO_DATA_O  = fdata_q;
	assign FIFO_FLUSH_O = flush_q;
	assign FIFO_LINES_O = lines;
	assign BUSY_O       = act_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	a_tt_read_code: assert property (!TS_N_O && rd_q |-> TT_O == (inv_q ? 5'h0e : 5'h0a))
		else $error("read transfer type wrong");
	a_tt_write_code: assert property (!TS_N_O && !rd_q |-> TT_O == (TBST_N_O ? 5'h02 : 5'h06))
		else $error("write transfer type wrong");
	a_gbl_whole_xfer: assert property ($rose(st_q == ST_REQ) |-> (GBL_N_O == !gbl_q) throughout
		(st_q != ST_IDLE)[*3])
		else $error("global snoop not held over transfer");
	a_hog_request: assert property (hog_q && act_q |-> !BR_N_O)
		else $error("hog request dropped");
	a_req_no_hog: assert property (!hog_q && (st_q != ST_REQ) |-> BR_N_O)
		else $error("request without need");
	a_wr_start_lvl: assert property ($rose(st_q == ST_REQ) && !rd_q && $past(WRITE_POST_ENABLE_I)
		&& !$past(cont_q) && !$past(done_q) |-> $past(lines) >= 4'h4 - {2'b00,
		$past(WRITE_FIFO_THRESHOLD_I)})
		else $error("write started below threshold");
	a_wr_nopost: assert property ($rose(st_q == ST_REQ) && !rd_q |-> $past(occ_q) != '0)
		else $error("write started with empty fifo");
	a_rd_limit: assert property (!TS_N_O && rd_q |-> ADDR_O <= lim_q)
		else $error("read past window end");
	a_flush_after: assert property (finish && rd_q |=> FIFO_FLUSH_O ##1 !FIFO_FLUSH_O)
		else $error("residual data not flushed");
	a_rd_skip_beats: assert property (FIFO_PUSH_O |-> $past(beat_q) >= $past(skip_q))
		else $error("low beat kept");
	a_xfer_whole: assert property ((st_q == ST_DATA) && !last |=> st_q == ST_DATA)
		else $error("transfer abandoned");

	c_wr_burst: cover property (!TS_N_O && !rd_q && !TBST_N_O);
	c_rd_skip: cover property (!TS_N_O && rd_q && skip_q != 2'h0);
	c_flush: cover property (FIFO_FLUSH_O);
	c_hog: cover property (hog_q && act_q && (st_q == ST_IDLE));

endmodule

`default_nettype wire

// ---- tb/pib_bus_model.sv ----
// Purpose: processor bus arbiter and memory model facing the inbound master
// Assumes: one data beat every second cycle; grant follows the request
// Notes:   slow_i holds the grant back three cycles to stall the master
`timescale 1ns/100ps
`default_nettype none

module pib_bus_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        slow_i,
	input  wire logic        br_n_i,
	input  wire logic        ts_n_i,
	input  wire logic        tbst_n_i,
	output logic             bg_n_o,
	output logic             aack_n_o,
	output logic             ta_n_o,
	output logic [63:0]      data_o
);
	// ********
	// tenures
	// ********
	logic [2:0]  beats;
	logic        gap;
	logic [1:0]  hold;
	logic [31:0] pat;

	always @(negedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bg_n_o   <= 1'b1;
			aack_n_o <= 1'b1;
			ta_n_o   <= 1'b1;
			beats    <= 3'h0;
			gap      <= 1'b0;
			hold     <= 2'h0;
			pat      <= 32'h0;
			data_o   <= 64'h0;
		end else begin
			hold     <= (br_n_i || !slow_i) ? 2'h0 : hold + 2'h1;
			bg_n_o   <= br_n_i || (slow_i && hold != 2'h3);
			aack_n_o <= ts_n_i;
			pat      <= pat + 32'h1;
			// off-beat data breaks the upper/lower pairing, so a late sample shows
			data_o   <= {pat, pat};
			ta_n_o   <= 1'b1;
			gap      <= 1'b0;
			if (!ts_n_i) begin
				beats <= tbst_n_i ? 3'h1 : 3'h4;
			end else if (beats != 3'h0 && !gap) begin
				ta_n_o <= 1'b0;
				data_o <= {~pat, pat};
				beats  <= beats - 3'h1;
				gap    <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/pci_inbound_cpu_bus_master_bench.sv ----
// Purpose: self-checking bench for the inbound processor-bus master
// Assumes: pci side is played by start, done, push and pop pulses
// Notes:   write data is held constant, so drain order is not checked
`timescale 1ns/100ps
`default_nettype none

module pci_inbound_cpu_bus_master_bench;
	import pib_pkg::*;
	// ********
	// signals
	// ********
	logic        clk, rstn, wpe, rae, intent_modify_select, global_attr_select, hog, start, done, frame, push, pop, slow, is_wr;
	logic [1:0]  wft, rft, read_multiple_fifo_threshold;
	logic [3:0]  cmd, lines;
	logic [31:0] addr, limit, addr_o, first_a;
	logic [63:0] wdat, fdat_o, dat_o, dat_i;
	logic [4:0]  tt;
	logic        pop_o, push_o, flush_o, busy, br_n, bg_n, ts_n, tbst_n, gbl_n, aack_n, ta_n;
	int          fails, n_tests, n_push, n_ts, n_flush;

	pib_cpu_master dut_u (
		.CLK_I(clk), .RSTN_I(rstn), .WRITE_POST_ENABLE_I(wpe), .WRITE_FIFO_THRESHOLD_I(wft),
		.READ_AHEAD_ENABLE_I(rae), .READ_FIFO_THRESHOLD_I(rft),
		.READ_MULTIPLE_FIFO_THRESHOLD_I(read_multiple_fifo_threshold), .INTENT_MODIFY_SELECT_I(intent_modify_select),
		.GLOBAL_ATTR_SELECT_I(global_attr_select), .MASTER_BUS_HOG_ENABLE_I(hog), .XACT_START_I(start),
		.XACT_CMD_I(cmd), .XACT_ADDR_I(addr), .XACT_LIMIT_I(limit), .XACT_DONE_I(done),
		.PCI_FRAME_ACTIVE_I(frame), .FIFO_PUSH_I(push), .FIFO_POP_I(pop), .FIFO_DATA_I(wdat),
		.FIFO_POP_O(pop_o), .FIFO_PUSH_O(push_o), .FIFO_DATA_O(fdat_o), .FIFO_FLUSH_O(flush_o),
		.FIFO_LINES_O(lines), .BUSY_O(busy), .BR_N_O(br_n), .BG_N_I(bg_n), .TS_N_O(ts_n),
		.ADDR_O(addr_o), .TT_O(tt), .TBST_N_O(tbst_n), .GBL_N_O(gbl_n), .AACK_N_I(aack_n),
		.TA_N_I(ta_n), .DATA_O(dat_o), .DATA_I(dat_i)
	);
	pib_bus_model bus_u (
		.clk_i(clk), .rstn_i(rstn), .slow_i(slow), .br_n_i(br_n), .ts_n_i(ts_n),
		.tbst_n_i(tbst_n), .bg_n_o(bg_n), .aack_n_o(aack_n), .ta_n_o(ta_n), .data_o(dat_i)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ********
	// tasks
	// ********
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t ns: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic feed(input int n);
		push = 1'b1;
		tick(n);
		push = 1'b0;
	endtask
	task automatic drain(input int n);
		if (n > 0) begin
			pop = 1'b1;
			tick(n);
			pop = 1'b0;
		end
	endtask
	function automatic logic ready(input int m, input int v);
		case (m)
			0: return busy === 1'b0;
			1: return br_n === 1'b0;
			2: return n_push >= v;
			default: return n_ts >= v;
		endcase
	endfunction
	// every wait is bounded; running out ends the run
	task automatic wait_on(input int m, input int v);
		int i;
		for (i = 0; i < 600 && !ready(m, v); i++)
			tick(1);
		if (i == 600) begin
			fails++;
			$display("[ERR] %0t ns: wait ran out", $time);
			print_verdict();
		end
	endtask
	task automatic begin_xact(input logic [3:0] c, input logic [31:0] a);
		cmd = c;
		addr = a;
		is_wr = (c == CMD_MEM_WRITE) || (c == CMD_MEM_WRITE_INV);
		n_push = 0;
		n_ts = 0;
		n_flush = 0;
		start = 1'b1;
		tick(1);
		start = 1'b0;
	endtask
	task automatic end_xact();
		done = 1'b1;
		tick(1);
		done = 1'b0;
		wait_on(0, 0);
		// one more edge so the monitor has counted the flush pulse
		tick(1);
	endtask

	// ********
	// monitor
	// ********
	always @(posedge clk) begin
		if (flush_o === 1'b1)
			n_flush++;
		if (push_o === 1'b1) begin
			n_push++;
			check(fdat_o[63:32], {32'h0, ~fdat_o[31:0]});
		end
		if (ts_n === 1'b0) begin
			if (n_ts == 0)
				first_a = addr_o;
			n_ts++;
			check(gbl_n, !global_attr_select);
			check(addr_o + (tbst_n ? 32'h7 : 32'h1f) <= limit, 1'b1);
			if (is_wr)
				check(tt, tbst_n ? TT_WRITE_FLUSH : TT_WRITE_KILL);
			else
				check(tt, intent_modify_select ? TT_READ_MODIFY : TT_READ);
		end
		if (ta_n === 1'b0 && is_wr) begin
			check(dat_o, wdat);
			check(pop_o, 1'b1);
		end
	end

	// ********
	// sequence
	// ********
	initial begin
		{rstn, wpe, rae, intent_modify_select, global_attr_select, hog, start, done, frame, push, pop, slow, is_wr} = 13'h0;
		{wft, rft, read_multiple_fifo_threshold, cmd, addr, first_a} = '0;
		limit = 32'hffff;
		wdat = 64'h0123_4567_89ab_cdef;
		{fails, n_tests, n_push, n_ts, n_flush} = '0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		tick(1);
		check({br_n, ts_n, gbl_n, busy}, 4'he);
		begin_xact(CMD_MEM_WRITE_INV, 32'h108);
		tick(3);
		check(br_n, 1'b1);
		feed(1);
		wait_on(3, 1);
		check({first_a, tbst_n}, {32'h108, 1'b1});
		end_xact();
		wpe = 1'b1;
		for (int c = 0; c < 4; c++) begin
			wft = c[1:0];
			global_attr_select = c[0];
			begin_xact(CMD_MEM_WRITE, 32'h200);
			feed((4 - c) * 4 - 1);
			tick(3);
			check(br_n, 1'b1);
			feed(1);
			wait_on(3, 4 - c);
			check({first_a, tbst_n}, {32'h200, 1'b0});
			end_xact();
		end
		wpe = 1'b0;
		{hog, intent_modify_select} = 2'b11;
		begin_xact(CMD_MEM_WRITE, 32'h300);
		feed(1);
		wait_on(3, 1);
		tick(8);
		check(br_n, 1'b0);
		end_xact();
		hog = 1'b0;
		intent_modify_select = 1'b1;
		begin_xact(CMD_MEM_READ, 32'h400);
		wait_on(2, 4);
		tick(6);
		check(n_push, 4);
		frame = 1'b1;
		drain(1);
		wait_on(2, 8);
		frame = 1'b0;
		drain(1);
		tick(6);
		check(n_push, 8);
		end_xact();
		check(n_flush, 1);
		slow = 1'b1;
		for (int c = 0; c < 4; c++) begin
			intent_modify_select = c[0];
			global_attr_select = c[1];
			rae = ~c[0];
			rft = c[0] ? ~c[1:0] : c[1:0];
			read_multiple_fifo_threshold = c[0] ? c[1:0] : ~c[1:0];
			begin_xact(c[0] ? CMD_MEM_READ_MULT : (c == 0 ? CMD_MEM_READ_LINE : CMD_MEM_READ), 32'h600);
			wait_on(2, 16);
			drain((3 - c) * 4);
			tick(6);
			check(n_push, 16);
			check(lines, c + 1);
			drain(4);
			wait_on(2, 32);
			tick(6);
			check(n_push, 32);
			check(lines, c + 4);
			end_xact();
			check(n_flush, 1);
			check(lines, 0);
		end
		slow = 1'b0;
		{rae, rft} = 3'h4;
		limit = 32'h83f;
		begin_xact(CMD_MEM_READ_LINE, 32'h810);
		wait_on(2, 6);
		tick(12);
		check(n_push, 6);
		check(first_a, 32'h800);
		end_xact();
		print_verdict();
	end
endmodule
`default_nettype wire
